// *** hw/fqb_burst_cfg.sv ***
// Read configuration register: burst length code and word width choice
// Assumes writes arrive as one-cycle strobes from the register bus
`timescale 1ns/1ps
`include "fqb_defs.svh"
module fqb_burst_cfg (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Write port
   input wire logic wr_en,
   input wire logic [3:0] wr_data,
   // Setting
   output logic [3:0] cfg,
   output fqb_pkg::fqb_burst_t burst
);
   import fqb_pkg::*;

   logic [3:0] cfg_ff;
   logic [3:0] nxt_cfg;
   fqb_burst_t burst_ff;
   fqb_burst_t nxt_burst;
   wire logic [2:0] sel_code = nxt_cfg[`FQB_RCFG_BL_MSB:`FQB_RCFG_BL_LSB];

   // Capability code is taken unchanged into the low three bits
   assign nxt_cfg = wr_en ? wr_data : cfg_ff; // see RL6
   assign nxt_burst = '{code: sel_code, cont: (sel_code == `FQB_BL_CONT),
                        narrow: nxt_cfg[`FQB_RCFG_NARROW_BIT],
                        len_words: fqb_burst_words(sel_code)};

   // Register and decoded copy
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_ff <= `FQB_RCFG_RST;
         burst_ff <= '{code: 3'h7, cont: 1'b1, narrow: 1'b0, len_words: 8'h00};
      end else begin
         cfg_ff <= nxt_cfg;
         burst_ff <= nxt_burst;
      end
   end

   assign cfg = cfg_ff;
   assign burst = burst_ff;
endmodule

// *** hw/fqb_cap_rom.sv ***
// Constant query bytes of the page and burst capability slice
// Assumes the caller qualifies reads with query mode
`timescale 1ns/1ps
`include "fqb_defs.svh"
module fqb_cap_rom #(
   parameter logic [7:0] PART_REGIONS = `FQB_VAL_PREG
) (
   // Lookup
   input wire logic [7:0] idx,
   output logic [7:0] data,
   output logic hit
);
   import fqb_pkg::*;

   // Index to constant byte; capability codes keep bits 7:3 clear, see RL4
   function automatic logic [8:0] lookup(input logic [7:0] i);
      case (i)
         `FQB_IDX_PAGE: lookup = {1'b1, `FQB_VAL_PAGE}; // see RL1 see RL2
         `FQB_IDX_BCNT: lookup = {1'b1, `FQB_VAL_BCNT}; // see RL3
         `FQB_IDX_CAP1: lookup = {1'b1, `FQB_VAL_CAP1}; // see RL7
         `FQB_IDX_CAP2: lookup = {1'b1, `FQB_VAL_CAP2}; // see RL7
         `FQB_IDX_CAP3: lookup = {1'b1, `FQB_VAL_CAP3}; // see RL7
         `FQB_IDX_CAP4: lookup = {1'b1, `FQB_VAL_CAP4}; // see RL5 see RL7
         `FQB_IDX_PREG: lookup = {1'b1, PART_REGIONS}; // see RL8
         default: lookup = 9'h000;
      endcase
   endfunction

   wire logic [8:0] entry = lookup(idx);
   assign hit = entry[8];
   assign data = entry[7:0];
endmodule

// *** hw/fqb_defs.svh ***
// Constants of the query table slice: indexes, byte values, own registers
// Assumes a byte address bus where each table entry takes one aligned word
`ifndef FQB_DEFS_SVH
`define FQB_DEFS_SVH

// Bus geometry
`define FQB_AW 10
`define FQB_DW 32

// Table indexes; the byte address is four times the index
`define FQB_IDX_PAGE 8'h4c
`define FQB_IDX_BCNT 8'h4d
`define FQB_IDX_CAP1 8'h4e
`define FQB_IDX_CAP2 8'h4f
`define FQB_IDX_CAP3 8'h50
`define FQB_IDX_CAP4 8'h51
`define FQB_IDX_PREG 8'h52

// Constant table bytes
`define FQB_VAL_PAGE 8'h03
`define FQB_VAL_BCNT 8'h04
`define FQB_VAL_CAP1 8'h01
`define FQB_VAL_CAP2 8'h02
`define FQB_VAL_CAP3 8'h03
`define FQB_VAL_CAP4 8'h07
`define FQB_VAL_PREG 8'h01

// Own control and status registers, by index
`define FQB_IDX_CTRL 8'h60
`define FQB_IDX_RCFG 8'h61
`define FQB_IDX_STAT 8'h62

// Field positions and reset values
`define FQB_CTRL_QRY_BIT 0
`define FQB_CTRL_RST 1'b0
`define FQB_RCFG_BL_LSB 0
`define FQB_RCFG_BL_MSB 2
`define FQB_RCFG_NARROW_BIT 3
`define FQB_RCFG_RST 4'h7
`define FQB_CAP_CODE_MSB 2
`define FQB_BL_CONT 3'h7

`endif

// *** hw/fqb_pkg.sv ***
// Types shared by the query table slice
// Assumes fqb_defs.svh is on the include path
package fqb_pkg;
   `include "fqb_defs.svh"

   // One register bus request
   typedef struct packed {
      logic [`FQB_AW-1:0] addr;
      logic [`FQB_DW-1:0] wdata;
      logic wr;
      logic rd;
   } fqb_bus_req_t;

   // Burst setting presented to the read path
   typedef struct packed {
      logic [2:0] code;
      logic cont;
      logic narrow;
      logic [7:0] len_words;
   } fqb_burst_t;

   // Words per burst for a capability code; zero stands for continuous
   function automatic logic [7:0] fqb_burst_words(input logic [2:0] code);
      fqb_burst_words = (code == `FQB_BL_CONT) ? 8'h00 : (8'h02 << code);
   endfunction
endpackage

// *** hw/fqb_query_top.sv ***
// Query table slice: page and burst capability bytes, partition region count,
// plus query mode control and the read configuration burst bits.
// Assumes a plain register port: one-cycle strobes, read data one cycle later.
//
// Overview of operation
// RL1 - Page capability byte reads 03, eight bytes
// RL2 - Page byte is exponent; zero means no page
// RL3 - Burst field count reads 04
// RL4 - Capability fields: three-bit exponent, upper bits zero
// RL5 - Code seven means continuous linear burst
// RL6 - Capability code loads unchanged into config bits
// RL7 - Fields read 01, 02, 03, 07
// RL8 - Region count byte; zero means single partition
// RL9 - Query reads return constants regardless of history
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`include "fqb_defs.svh"
module fqb_query_top #(
   parameter logic [7:0] PART_REGIONS = `FQB_VAL_PREG
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Register bus
   input wire fqb_pkg::fqb_bus_req_t req,
   output logic [`FQB_DW-1:0] rdata,
   // Block state
   output logic query_mode,
   output fqb_pkg::fqb_burst_t burst
);
   import fqb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   wire logic [7:0] idx = req.addr[`FQB_AW-1:2];
   wire logic aligned = (req.addr[1:0] == 2'b00);
   wire logic sel_ctrl = aligned && (idx == `FQB_IDX_CTRL);
   wire logic sel_rcfg = aligned && (idx == `FQB_IDX_RCFG);
   wire logic sel_stat = aligned && (idx == `FQB_IDX_STAT);
   wire logic wr_ctrl = req.wr && sel_ctrl;
   wire logic wr_rcfg = req.wr && sel_rcfg;

   ////////////////////////////////////////////////////////////////////////
   // Constant table

   logic [7:0] rom_data;
   logic rom_hit;

   fqb_cap_rom #(
      .PART_REGIONS(PART_REGIONS)
   ) u_rom (
      .idx(idx),
      .data(rom_data),
      .hit(rom_hit)
   );

   logic query_mode_ff;

   // Table bytes appear only in query mode and on aligned words
   wire logic tbl_sel = aligned && rom_hit && query_mode_ff; // see RL9

   ////////////////////////////////////////////////////////////////////////
   // Query mode control

   logic nxt_query_mode;

   assign nxt_query_mode = wr_ctrl ? req.wdata[`FQB_CTRL_QRY_BIT] : query_mode_ff;

   // Query mode flag
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         query_mode_ff <= `FQB_CTRL_RST;
      end else begin
         query_mode_ff <= nxt_query_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read configuration

   logic [3:0] rcfg;

   fqb_burst_cfg u_cfg (
      .clk(clk),
      .rst_b(rst_b),
      .wr_en(wr_rcfg), // see RL6
      .wr_data(req.wdata[3:0]),
      .cfg(rcfg),
      .burst(burst)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read data path

   logic [`FQB_DW-1:0] rdata_ff;
   logic [`FQB_DW-1:0] nxt_rdata;

   // Status word: query mode, burst code, continuous flag, width bit, burst words
   wire logic [`FQB_DW-1:0] stat_word = {16'h0000, burst.len_words, 2'b00,
                                         burst.narrow, burst.cont, burst.code,
                                         query_mode_ff};

   // Selection of read data; unmapped reads give zero
   wire logic [`FQB_DW-1:0] rd_word =
      tbl_sel ? {24'h000000, rom_data} : // see RL9
      sel_ctrl ? {31'h00000000, query_mode_ff} :
      sel_rcfg ? {28'h0000000, rcfg} :
      sel_stat ? stat_word :
      32'h00000000;

   // Data stands only in the cycle after the read strobe
   assign nxt_rdata = req.rd ? rd_word : 32'h00000000;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= 32'h00000000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign rdata = rdata_ff;
   assign query_mode = query_mode_ff;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   wire logic rd_q = req.rd && query_mode_ff && aligned;
   wire logic [2:0] wr_code = req.wdata[2:0];

   property p_page_val;
      rd_q && (idx == `FQB_IDX_PAGE) |=> (rdata == 32'h00000003);
   endproperty
   a_page_val: assert property (p_page_val) // see RL1
      else $error("page capability byte wrong");

   property p_page_pow;
      rd_q && (idx == `FQB_IDX_PAGE) |=> ((8'h01 << rdata[7:0]) == 8'h08);
   endproperty
   a_page_pow: assert property (p_page_pow) // see RL2
      else $error("page size is not eight bytes");

   property p_bcnt;
      rd_q && (idx == `FQB_IDX_BCNT) |=> (rdata[7:0] == 8'h04) && (rdata[31:8] == 24'h0);
   endproperty
   a_bcnt: assert property (p_bcnt) // see RL3
      else $error("burst field count wrong");

   property p_cap_resv;
      rd_q && (idx >= `FQB_IDX_CAP1) && (idx <= `FQB_IDX_CAP4) |=> (rdata[7:3] == 5'h00);
   endproperty
   a_cap_resv: assert property (p_cap_resv) // see RL4
      else $error("capability reserved bits set");

   property p_cap_cont;
      rd_q && (idx == `FQB_IDX_CAP4) |=> (rdata[2:0] == 3'h7);
   endproperty
   a_cap_cont: assert property (p_cap_cont) // see RL5
      else $error("fourth capability is not continuous");

   property p_rcfg_load;
      req.wr && sel_rcfg |=> (burst.code == $past(wr_code)) ##0
         (burst.cont == (burst.code == 3'h7));
   endproperty
   a_rcfg_load: assert property (p_rcfg_load) // see RL6
      else $error("burst code not loaded unchanged");

   property p_cap_seq;
      rd_q && (idx >= `FQB_IDX_CAP1) && (idx <= `FQB_IDX_CAP3)
         |=> (rdata[7:0] == ($past(idx) - 8'h4d));
   endproperty
   a_cap_seq: assert property (p_cap_seq) // see RL7
      else $error("capability field value wrong");

   property p_preg;
      rd_q && (idx == `FQB_IDX_PREG) |=> (rdata[7:0] == PART_REGIONS);
   endproperty
   a_preg: assert property (p_preg) // see RL8
      else $error("partition region count wrong");

   property p_repeat;
      rd_q && rom_hit ##1 req.rd && ($past(req.addr) == req.addr) && query_mode_ff
         |=> (rdata == $past(rdata));
   endproperty
   a_repeat: assert property (p_repeat) // see RL9
      else $error("query byte changed between reads");

   property p_no_query;
      req.rd && !query_mode_ff && rom_hit |=> (rdata == 32'h00000000);
   endproperty
   a_no_query: assert property (p_no_query) // see RL9
      else $error("table byte visible outside query mode");

   property p_rd_pulse;
      !req.rd |=> (rdata == 32'h00000000);
   endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read data stands too long");

   // Nonzero page exponent: a read page buffer is present
   property p_page_nz;
      rd_q && (idx == `FQB_IDX_PAGE) |=> (rdata[7:0] != 8'h00);
   endproperty
   a_page_nz: assert property (p_page_nz) // see RL2
      else $error("page capability says no page buffer");

   // Fields one to three advertise four, eight and sixteen words
   property p_cap_len;
      rd_q && (idx >= `FQB_IDX_CAP1) && (idx <= `FQB_IDX_CAP3)
         |=> ((8'h02 << rdata[2:0]) == (8'h04 << ($past(idx) - `FQB_IDX_CAP1)));
   endproperty
   a_cap_len: assert property (p_cap_len) // see RL7
      else $error("advertised burst length wrong");

   // Fixed burst length is two to the power code plus one
   property p_bl_words;
      !burst.cont |-> (burst.len_words == (8'h02 << burst.code));
   endproperty
   a_bl_words: assert property (p_bl_words) // see RL4
      else $error("burst length does not match code");

   // Continuous setting carries code seven and no length
   property p_bl_cont;
      burst.cont |-> (burst.code == `FQB_BL_CONT) && (burst.len_words == 8'h00);
   endproperty
   a_bl_cont: assert property (p_bl_cont) // see RL5
      else $error("continuous burst setting inconsistent");

   // Width bit of the configuration follows the write
   property p_rcfg_narrow;
      wr_rcfg |=> (burst.narrow == $past(req.wdata[`FQB_RCFG_NARROW_BIT]));
   endproperty
   a_rcfg_narrow: assert property (p_rcfg_narrow) // see RL6
      else $error("width bit not loaded");

   // Without a write the configuration keeps its value
   property p_rcfg_hold;
      !wr_rcfg |=> $stable(burst) && $stable(rcfg);
   endproperty
   a_rcfg_hold: assert property (p_rcfg_hold) // see RL6
      else $error("burst setting changed without a write");

   // Configuration reads back as written
   property p_rcfg_rd;
      req.rd && sel_rcfg |=> (rdata == {28'h0000000, $past(rcfg)});
   endproperty
   a_rcfg_rd: assert property (p_rcfg_rd) // see RL6
      else $error("configuration read back wrong");

   // Query mode follows bit zero of a control write
   property p_qry_set;
      wr_ctrl |=> (query_mode_ff == $past(req.wdata[`FQB_CTRL_QRY_BIT]));
   endproperty
   a_qry_set: assert property (p_qry_set) // see RL9
      else $error("query mode not taken from control write");

   // Without a control write query mode is kept
   property p_qry_hold;
      !wr_ctrl |=> $stable(query_mode_ff);
   endproperty
   a_qry_hold: assert property (p_qry_hold) // see RL9
      else $error("query mode changed without a write");

   // Table bytes sit in the low byte, upper bits clear
   property p_tbl_upper;
      rd_q && rom_hit |=> (rdata[31:8] == 24'h000000);
   endproperty
   a_tbl_upper: assert property (p_tbl_upper) // see RL9
      else $error("table read has upper bits set");

   // Writes to the table change nothing
   property p_tbl_ro;
      req.wr && rom_hit |=> $stable(query_mode_ff) && $stable(burst);
   endproperty
   a_tbl_ro: assert property (p_tbl_ro) // see RL9
      else $error("table write changed block state");

   // Misaligned reads give zero
   property p_misalign;
      req.rd && !aligned |=> (rdata == 32'h00000000);
   endproperty
   a_misalign: assert property (p_misalign)
      else $error("misaligned read returned data");

   // Control word reads back the mode bit
   property p_ctrl_rd;
      req.rd && sel_ctrl |=> (rdata == {31'h00000000, $past(query_mode_ff)});
   endproperty
   a_ctrl_rd: assert property (p_ctrl_rd)
      else $error("control read back wrong");

   // Status word mirrors mode and burst code
   property p_stat_rd;
      req.rd && sel_stat |=> (rdata[0] == $past(query_mode_ff)) &&
         (rdata[3:1] == $past(burst.code));
   endproperty
   a_stat_rd: assert property (p_stat_rd)
      else $error("status read back wrong");

   // Main scenarios
   c_page_rd: cover property (rd_q && (idx == `FQB_IDX_PAGE) ##1 rdata[7:0] == 8'h03);
   c_cont_wr: cover property (req.wr && sel_rcfg && (wr_code == 3'h7) ##1 burst.cont);
   c_cap_all: cover property (rd_q && (idx == `FQB_IDX_CAP1) ##1 rd_q && (idx == `FQB_IDX_CAP4));
   c_off_rd: cover property (req.rd && !query_mode_ff && rom_hit);
   c_rep_rd: cover property (rd_q && rom_hit ##1 req.rd && rd_q);
endmodule

// *** sim/fqb_host.sv ***
// Host model: issues one-cycle strobes on the query slice register port
// Assumes one bench process calls its tasks, never two at once
`timescale 1ns/1ps
module fqb_host (
   // Clock
   input wire logic clk,
   // Register port
   output fqb_pkg::fqb_bus_req_t req,
   input wire logic [31:0] rdata
);
   import fqb_pkg::*;
   ////////////////////////////////////////////////////////////////
   // Idle bus at time zero
   initial begin
      req = '0;
   end
   // Write strobe; released bus shows inverted address and data
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      #1;
   endtask
   // Read strobe; data taken in the cycle after, then the idle cycle
   task automatic rd(input logic [9:0] a, output logic [31:0] d, output logic [31:0] z);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h5a5a_a5a5, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: ~a, wdata: 32'ha5a5_5a5a, wr: 1'b0, rd: 1'b0};
      #1 d = rdata;
      @(posedge clk);
      #1 z = rdata;
   endtask
   // Two reads with no gap; each word is taken in the cycle after its strobe
   task automatic rd2(input logic [9:0] a1, input logic [9:0] a2,
                      output logic [31:0] d1, output logic [31:0] d2);
      @(posedge clk);
      req <= '{addr: a1, wdata: 32'h5a5a_a5a5, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: a2, wdata: 32'h5a5a_a5a5, wr: 1'b0, rd: 1'b1};
      #1 d1 = rdata;
      @(posedge clk);
      req <= '{addr: ~a2, wdata: 32'ha5a5_5a5a, wr: 1'b0, rd: 1'b0};
      #1 d2 = rdata;
   endtask
endmodule

// *** sim/fqb_query_top_bench.sv ***
// Bench for the query slice: model of table and own registers, host model
// Assumes fqb_defs.svh is on the include path
`timescale 1ns/1ps
`include "fqb_defs.svh"
module fqb_query_top_bench;
   import fqb_pkg::*;
   localparam logic [7:0] PR = 8'h02;
   logic clk;
   logic rst_b;
   fqb_bus_req_t req;
   logic [31:0] rdata;
   logic query_mode;
   fqb_burst_t burst;
   int num_errors = 0;
   int n_compared = 0;
   int q = 0;
   int rcfg = 7;
   int tbl[7] = '{3, 4, 1, 2, 3, 7, 2};
   ////////////////////////////////////////////////////////////////
   // Design and host
   fqb_query_top #(.PART_REGIONS(PR)) DUT (.clk(clk), .rst_b(rst_b), .req(req),
      .rdata(rdata), .query_mode(query_mode), .burst(burst));
   fqb_host host (.clk(clk), .req(req), .rdata(rdata));
   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   // Expected burst setting from the model
   function automatic logic [12:0] exp_burst();
      int c;
      int len;
      c = rcfg % 8;
      len = (c == 7) ? 0 : (2 << c);
      return {3'(c), c == 7, rcfg >= 8, 8'(len)};
   endfunction
   // Expected read data for a byte address
   function automatic logic [31:0] exp_rd(input int a);
      logic [12:0] b;
      b = exp_burst();
      if (a % 4 != 0) return 0;
      if (q == 1 && a >= 'h130 && a <= 'h148) return tbl[(a - 'h130) / 4];
      if (a == 'h180) return q;
      if (a == 'h184) return rcfg;
      if (a == 'h188) return {b[7:0], 2'b00, b[8], b[9], b[12:10], q[0]};
      return 0;
   endfunction
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One bus operation with model update and output checks
   task automatic op(input logic w, input logic [9:0] a, input logic [31:0] d);
      logic [31:0] g;
      logic [31:0] z;
      if (w) begin
         host.wr(a, d);
         if (a == 10'h180) q = d[0];
         if (a == 10'h184) rcfg = d[3:0];
      end else begin
         host.rd(a, g, z);
         chk(g, exp_rd(a));
         chk(z, 32'h0);
      end
      chk({31'h0, query_mode}, q);
      chk({19'h0, burst}, {19'h0, exp_burst()});
   endtask
   // Verdict and end of run
   task automatic complete_run();
      if (num_errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      #40000;
      num_errors++;
      complete_run();
   end
   // Main sequence
   initial begin
      logic [31:0] g;
      logic [31:0] z;
      logic [9:0] a;
      rst_b = 1'b0;
      void'($urandom(91374));
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 7; i++) op(1'b0, 10'h130 + 10'(4 * i), 0);
      op(1'b0, 10'h188, 0);
      op(1'b1, 10'h180, 32'h1);
      for (int i = 0; i < 7; i++) op(1'b0, 10'h130 + 10'(4 * i), 0);
      host.rd2(10'h140, 10'h140, g, z);
      chk(g, exp_rd('h140));
      chk(z, exp_rd('h140));
      host.rd2(10'h138, 10'h144, g, z);
      chk(g, exp_rd('h138));
      chk(z, exp_rd('h144));
      op(1'b1, 10'h130, 32'hff);
      op(1'b0, 10'h130, 0);
      for (int i = 2; i < 6; i++) begin
         host.rd(10'h130 + 10'(4 * i), g, z);
         chk(g & 32'hf8, 0);
         chk(z, 32'h0);
         op(1'b1, 10'h184, g);
         op(1'b0, 10'h188, 0);
      end
      for (int i = 0; i < 80; i++) begin
         a = 10'h12c + 10'($urandom % 100);
         if ($urandom % 4 != 0) a[1:0] = 2'b00;
         op(1'($urandom % 3 == 0), a, $urandom);
      end
      complete_run();
   end
endmodule
